// >>> fwlc_pkg.sv
package fwlc_pkg;

   // ------------------------------------------------------------------
   // Storage geometry
   // ------------------------------------------------------------------
   localparam int FIFO_DEPTH = 96; // Bytes held by the shared FIFO.
   localparam int CNT_W = 7; // Width of pointers and byte count.
   localparam int FRAME_W = 13; // Width of the programmed frame length.
   localparam logic [6:0] DEPTH_CNT = 7'd96; // Depth at the count's width.
   localparam logic [6:0] LAST_PTR = 7'd95; // Highest pointer before wrap.
   localparam logic [6:0] CNT_ONE = 7'd1; // Unit step of count and pointers.
   localparam logic [6:0] CNT_ZERO = 7'd0; // Empty count and pointer reset.

   // ------------------------------------------------------------------
   // Water levels and the short-load low mark
   // ------------------------------------------------------------------
   localparam logic [6:0] RX_WL0 = 7'd80; // Receive level, select bit low.
   localparam logic [6:0] RX_WL1 = 7'd64; // Receive level, select bit high.
   localparam logic [6:0] TX_WL0 = 7'd32; // Transmit level, select bit low.
   localparam logic [6:0] TX_WL1 = 7'd16; // Transmit level, select bit high.
   localparam logic [6:0] TX_LOW_MARK = 7'd4; // Count below which a short load is topped up.

   // ------------------------------------------------------------------
   // Direct command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_CLEAR_A = 8'hc2; // Stop and empty.
   localparam logic [7:0] CMD_CLEAR_B = 8'hc3; // Stop and empty, alias.
   localparam logic [7:0] CMD_TX_CRC = 8'hc4; // Transmit with appended check sum.
   localparam logic [7:0] CMD_TX_NOCRC = 8'hc5; // Transmit without check sum.
   localparam logic [7:0] CMD_MASK_RX = 8'hd0; // Ignore received data.

   // ------------------------------------------------------------------
   // Activity of the FIFO
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_TX,
      MODE_RX
   } fwlc_mode_t;

endpackage : fwlc_pkg

// >>> fwlc_xfer.sv
`timescale 1ns/100ps
`default_nettype none
// Toggle handshake carrying one word across clock domains.
module fwlc_xfer #(
   parameter int W = 8
) (
   // Clocks and reset.
   input wire logic src_clk,
   input wire logic dst_clk,
   input wire logic rst,
   // Source side.
   input wire logic src_valid,
   input wire logic [W-1:0] src_data,
   output logic src_busy,
   // Destination side.
   output logic dst_valid,
   output logic [W-1:0] dst_data
);

   // ------------------------------------------------------------------
   // Source domain
   // ------------------------------------------------------------------
   logic tog_reg; // Flips once per word sent.
   logic [W-1:0] word_reg; // Word held steady until acknowledged.
   logic ack_meta_reg; // First stage of the acknowledge synchroniser.
   logic ack_sync_reg; // Settled acknowledge.
   logic seen_reg; // Copy of the toggle, also the acknowledge.
   logic req_meta_reg; // First stage of the request synchroniser.
   logic req_sync_reg; // Settled request.

   // A word is in flight until its acknowledge returns.
   assign src_busy = tog_reg ^ ack_sync_reg;

   // Launch a word; a request while busy is dropped.
   always_ff @(posedge src_clk or posedge rst) begin
      if (rst) begin
         tog_reg <= 1'b0;
         word_reg <= '0;
      end else if (src_valid && !src_busy) begin
         tog_reg <= ~tog_reg;
         word_reg <= src_data;
      end
   end

   // Bring the acknowledge back through two flip-flops.
   always_ff @(posedge src_clk or posedge rst) begin
      if (rst) begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end else begin
         ack_meta_reg <= seen_reg;
         ack_sync_reg <= ack_meta_reg;
      end
   end

   // ------------------------------------------------------------------
   // Destination domain
   // ------------------------------------------------------------------
   // The word is stable while the toggles differ.
   always_ff @(posedge dst_clk or posedge rst) begin
      if (rst) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         seen_reg <= 1'b0;
         dst_valid <= 1'b0;
         dst_data <= '0;
      end else begin
         req_meta_reg <= tog_reg;
         req_sync_reg <= req_meta_reg;
         seen_reg <= req_sync_reg;
         dst_valid <= req_sync_reg ^ seen_reg;
         if (req_sync_reg ^ seen_reg) begin
            dst_data <= word_reg;
         end
      end
   end

endmodule : fwlc_xfer
`default_nettype wire

// >>> fwlc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - One 96 byte FIFO shared by both directions.
// - Transmit: level interrupt when count falls to level.
// - Receive: level interrupt when count rises to level.
// - Short transmit load: interrupt when count drops below 4.
// - No FIFO interrupts while host bursts with select low.
// - Level interrupt can be masked.
// - Two selectable levels each for receive, transmit.
// - Unread byte count readable at any time.
// - Overflow flag on write into full FIFO.
// - Underflow flag on read from empty FIFO.
// - Clear commands stop activity, empty FIFO, enable needed.
// - Transmit with check sum needs enable, transmit enable.
// - Transmit without check sum needs enable, transmit enable.
// - Mask command drops received data, needs receive enable.
// - Masked source still sets its flag.
// - Reading flag clears it; interrupt then falls.
module fwlc_fifo
   import fwlc_pkg::*;
#(
   parameter int DEPTH = fwlc_pkg::FIFO_DEPTH,
   parameter int FRAME_BITS = fwlc_pkg::FRAME_W
) (
   // System clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Link clock.
   input wire logic link_clk,
   // Serial select pin from the pad.
   input wire logic spi_ss_n,
   // Host byte port on the system clock.
   input wire logic host_wr_valid,
   input wire logic [7:0] host_wr_data,
   input wire logic host_rd_req,
   output logic host_rd_valid,
   output logic [7:0] host_rd_data,
   // Direct commands.
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   // Control and configuration bits.
   input wire logic op_en,
   input wire logic op_tx_en,
   input wire logic op_rx_en,
   input wire logic cfg_rx_wl_sel,
   input wire logic cfg_tx_wl_sel,
   input wire logic [fwlc_pkg::FRAME_W-1:0] tx_frame_bytes,
   input wire logic irq_mask_wl,
   input wire logic irq_read,
   // Status and interrupt.
   output logic [fwlc_pkg::CNT_W-1:0] fifo_count,
   output logic fifo_overflow,
   output logic fifo_underflow,
   output logic irq_wl_flag,
   output logic irq,
   output logic tx_start,
   output logic tx_crc,
   output logic rx_masked,
   // Link side, on the link clock.
   input wire logic link_rx_valid,
   input wire logic [7:0] link_rx_data,
   input wire logic link_tx_req,
   output logic link_tx_valid,
   output logic [7:0] link_tx_data,
   output logic link_tx_underrun
);

   // ------------------------------------------------------------------
   // Storage and state
   // ------------------------------------------------------------------
   logic [7:0] mem [0:DEPTH-1]; // Byte storage.
   logic [CNT_W-1:0] wr_ptr_reg; // Next slot to fill.
   logic [CNT_W-1:0] rd_ptr_reg; // Oldest unread slot.
   logic [CNT_W-1:0] cnt_reg; // Bytes not yet read.
   logic [CNT_W-1:0] cnt_next; // Count after this cycle.
   logic [FRAME_BITS-1:0] loaded_reg; // Bytes the host wrote for this frame.
   logic [FRAME_BITS-1:0] sent_reg; // Bytes handed to the transmitter.
   fwlc_mode_t mode_reg; // Current activity.
   logic ss_meta_reg; // First select synchroniser stage.
   logic ss_sync_reg; // Settled select, low while selected.
   logic burst_reg; // Host is in a FIFO load or read burst.
   logic rd_pend_reg; // Host read deferred by a transmit pop.
   logic [8:0] tx_word_reg; // Underrun flag and byte for the link.
   logic tx_word_valid_reg; // Pulse launching the byte to the link.

   // ------------------------------------------------------------------
   // Domain crossings
   // ------------------------------------------------------------------
   logic rx_valid; // Received byte arrived in the system domain.
   logic [7:0] rx_data; // That byte.
   logic tx_req; // Transmitter asked for a byte.
   logic [8:0] tx_back; // Word delivered to the link domain.

   // Received bytes travel link to system.
   fwlc_xfer #(.W(8)) u_rx_xfer (
      .src_clk(link_clk),
      .dst_clk(clk),
      .rst(sys_rst),
      .src_valid(link_rx_valid),
      .src_data(link_rx_data),
      .src_busy(),
      .dst_valid(rx_valid),
      .dst_data(rx_data)
   );

   // Byte requests travel link to system.
   fwlc_xfer #(.W(1)) u_req_xfer (
      .src_clk(link_clk),
      .dst_clk(clk),
      .rst(sys_rst),
      .src_valid(link_tx_req),
      .src_data(1'b0),
      .src_busy(),
      .dst_valid(tx_req),
      .dst_data()
   );

   // Answers travel system to link.
   fwlc_xfer #(.W(9)) u_tx_xfer (
      .src_clk(clk),
      .dst_clk(link_clk),
      .rst(sys_rst),
      .src_valid(tx_word_valid_reg),
      .src_data(tx_word_reg),
      .src_busy(),
      .dst_valid(link_tx_valid),
      .dst_data(tx_back)
   );

   assign link_tx_data = tx_back[7:0];
   assign link_tx_underrun = tx_back[8];

   // ------------------------------------------------------------------
   // Command decode and access arbitration
   // ------------------------------------------------------------------
   logic do_clear; // Accepted clear command.
   logic do_tx; // Accepted transmit command.
   logic do_mask; // Accepted receive mask command.
   logic full; // No free slot.
   logic empty; // Nothing to read.
   logic rx_take; // Received byte wants storing.
   logic host_take; // Host byte wants storing.
   logic push; // A byte goes into storage.
   logic [7:0] push_data; // The byte that goes in.
   logic tx_pop; // Transmitter reads this cycle.
   logic host_pop; // Host read served this cycle.
   logic pop; // The head byte leaves storage.
   logic wr_ovf; // A write hit a full FIFO or lost arbitration.
   logic [6:0] rx_wl; // Selected receive level.
   logic [6:0] tx_wl; // Selected transmit level.
   logic frame_open; // Host has not loaded the whole frame.
   logic wl_event; // A level crossing happened this cycle.

   assign do_clear = cmd_valid && op_en && (cmd_code == CMD_CLEAR_A || cmd_code == CMD_CLEAR_B);
   assign do_tx = cmd_valid && op_en && op_tx_en && (cmd_code == CMD_TX_CRC || cmd_code == CMD_TX_NOCRC);
   assign do_mask = cmd_valid && op_en && op_rx_en && cmd_code == CMD_MASK_RX;
   assign full = cnt_reg == DEPTH_CNT;
   assign empty = cnt_reg == CNT_ZERO;
   assign rx_take = rx_valid && op_rx_en && !rx_masked;
   assign host_take = host_wr_valid;
   assign tx_pop = tx_req && mode_reg == MODE_TX;
   assign host_pop = (host_rd_req || rd_pend_reg) && !tx_pop;
   assign pop = (tx_pop || host_pop) && !empty;
   // One write port: a received byte wins, a colliding host byte is lost.
   assign push = (rx_take || host_take) && (!full || pop);
   assign push_data = rx_take ? rx_data : host_wr_data;
   assign wr_ovf = (rx_take || host_take) && full && !pop || (rx_take && host_take);
   assign rx_wl = cfg_rx_wl_sel ? RX_WL1 : RX_WL0;
   assign tx_wl = cfg_tx_wl_sel ? TX_WL1 : TX_WL0;
   assign frame_open = loaded_reg < tx_frame_bytes;

   // Count after the push and pop of this cycle.
   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + CNT_ONE;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - CNT_ONE;
      end
   end

   // Level crossings; none is raised while a host burst owns the FIFO.
   always_comb begin
      wl_event = 1'b0;
      if (mode_reg == MODE_TX && frame_open) begin
         if (cnt_reg == tx_wl + CNT_ONE && cnt_next == tx_wl) begin
            wl_event = 1'b1;
         end
         if (loaded_reg < {{(FRAME_BITS-CNT_W){1'b0}}, tx_wl} && cnt_reg == TX_LOW_MARK
               && cnt_next < TX_LOW_MARK) begin
            wl_event = 1'b1;
         end
      end else if (mode_reg == MODE_RX) begin
         if (cnt_reg == rx_wl - CNT_ONE && cnt_next == rx_wl) begin
            wl_event = 1'b1;
         end
      end
      if (burst_reg || (!ss_sync_reg && (host_wr_valid || host_rd_req))) begin
         wl_event = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Serial select tracking
   // ------------------------------------------------------------------
   // The pad is asynchronous, so it is settled first.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ss_meta_reg <= 1'b1;
         ss_sync_reg <= 1'b1;
      end else begin
         ss_meta_reg <= spi_ss_n;
         ss_sync_reg <= ss_meta_reg;
      end
   end

   // A FIFO access under select starts a burst that lasts until select rises.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         burst_reg <= 1'b0;
      end else if (ss_sync_reg) begin
         burst_reg <= 1'b0;
      end else if (host_wr_valid || host_rd_req) begin
         burst_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Storage and pointers
   // ------------------------------------------------------------------
   // The array is not reset; the pointers alone define its content.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= push_data;
      end
   end

   // Pointers wrap at the last slot; a clear empties the FIFO at once.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= CNT_ZERO;
         rd_ptr_reg <= CNT_ZERO;
         cnt_reg <= CNT_ZERO;
      end else if (do_clear) begin
         wr_ptr_reg <= CNT_ZERO;
         rd_ptr_reg <= CNT_ZERO;
         cnt_reg <= CNT_ZERO;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? CNT_ZERO : wr_ptr_reg + CNT_ONE;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? CNT_ZERO : rd_ptr_reg + CNT_ONE;
         end
         cnt_reg <= cnt_next;
      end
   end

   // The count is always visible; it is updated in the same cycle as the transfer.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fifo_count <= CNT_ZERO;
      end else if (do_clear) begin
         fifo_count <= CNT_ZERO;
      end else begin
         fifo_count <= cnt_next;
      end
   end

   // ------------------------------------------------------------------
   // Activity sequencing
   // ------------------------------------------------------------------
   // Transmit runs for the programmed length, then reception follows if op_rx_en is set, else idle.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg <= MODE_IDLE;
         sent_reg <= '0;
         tx_start <= 1'b0;
         tx_crc <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         if (do_clear) begin
            mode_reg <= MODE_IDLE;
            sent_reg <= '0;
         end else if (do_tx) begin
            mode_reg <= MODE_TX;
            sent_reg <= '0;
            tx_start <= 1'b1;
            tx_crc <= cmd_code == CMD_TX_CRC;
         end else begin
            case (mode_reg)
               MODE_TX: begin
                  if (tx_req) begin
                     sent_reg <= sent_reg + {{(FRAME_BITS-1){1'b0}}, 1'b1};
                     if (sent_reg + {{(FRAME_BITS-1){1'b0}}, 1'b1} >= tx_frame_bytes) begin
                        mode_reg <= op_rx_en ? MODE_RX : MODE_IDLE;
                     end
                  end
               end
               MODE_IDLE: begin
                  if (rx_take) begin
                     mode_reg <= MODE_RX;
                  end
               end
               MODE_RX: begin
                  mode_reg <= MODE_RX;
               end
               default: begin
                  mode_reg <= MODE_IDLE;
               end
            endcase
         end
      end
   end

   // Bytes the host loaded count toward the frame until a clear.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         loaded_reg <= '0;
      end else if (do_clear) begin
         loaded_reg <= '0;
      end else if (host_take && push && !rx_take) begin
         loaded_reg <= loaded_reg + {{(FRAME_BITS-1){1'b0}}, 1'b1};
      end
   end

   // Receive masking holds until the next clear.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_masked <= 1'b0;
      end else if (do_clear) begin
         rx_masked <= 1'b0;
      end else if (do_mask) begin
         rx_masked <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Read answers
   // ------------------------------------------------------------------
   // A read meeting a transmit pop waits a cycle.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_pend_reg <= 1'b0;
         host_rd_valid <= 1'b0;
         host_rd_data <= 8'h00;
      end else begin
         rd_pend_reg <= (host_rd_req || rd_pend_reg) && tx_pop;
         host_rd_valid <= host_pop;
         if (host_pop) begin
            host_rd_data <= empty ? 8'h00 : mem[rd_ptr_reg];
         end
      end
   end

   // Every transmit request is answered; underrun when empty in transmit mode.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_word_valid_reg <= 1'b0;
         tx_word_reg <= 9'h000;
      end else begin
         tx_word_valid_reg <= tx_req;
         if (tx_req) begin
            tx_word_reg <= (tx_pop && !empty) ? {1'b0, mem[rd_ptr_reg]} : {tx_pop, 8'h00};
         end
      end
   end

   // ------------------------------------------------------------------
   // Error flags
   // ------------------------------------------------------------------
   // Flags stay set until a clear command.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fifo_overflow <= 1'b0;
         fifo_underflow <= 1'b0;
      end else if (do_clear) begin
         fifo_overflow <= 1'b0;
         fifo_underflow <= 1'b0;
      end else begin
         if (wr_ovf) begin
            fifo_overflow <= 1'b1;
         end
         if ((tx_pop || host_pop) && empty) begin
            fifo_underflow <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Water level interrupt
   // ------------------------------------------------------------------
   logic wl_flag_next; // Flag after set and read-clear.

   // A new event in the read cycle survives the clear.
   assign wl_flag_next = wl_event || (irq_wl_flag && !irq_read);

   // The flag is set even when masked; only the pin is gated.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_wl_flag <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq_wl_flag <= wl_flag_next;
         irq <= wl_flag_next && !irq_mask_wl;
      end
   end

endmodule : fwlc_fifo
`default_nettype wire

// >>> fwlc_fifo_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the shared FIFO, host clock domain only.
module fwlc_fifo_properties #(
   parameter int DEPTH = 96,
   parameter int FRAME_BITS = 13
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic host_wr_valid,
   input wire logic host_rd_req,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic op_en,
   input wire logic op_tx_en,
   input wire logic op_rx_en,
   input wire logic irq_mask_wl,
   input wire logic irq_read,
   input wire logic [fwlc_pkg::CNT_W-1:0] fifo_count,
   input wire logic fifo_overflow,
   input wire logic fifo_underflow,
   input wire logic irq_wl_flag,
   input wire logic irq,
   input wire logic tx_start,
   input wire logic tx_crc,
   input wire logic rx_masked
);
   import fwlc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // A clear may move the count by any amount.
   logic clr;
   assign clr = cmd_valid && op_en && (cmd_code == CMD_CLEAR_A || cmd_code == CMD_CLEAR_B);
   a_reset_zero: assert property (disable iff (1'b0) sys_rst |-> fifo_count == 7'h00 && !irq && !fifo_overflow)
      else $error("reset state wrong");
   a_count_step: assert property (!$past(clr) |-> 7'(fifo_count - $past(fifo_count) + 7'h01) <= 7'h02)
      else $error("count jumped");
   a_clear_empties: assert property (clr |=> fifo_count == 7'h00 && !fifo_overflow && !fifo_underflow)
      else $error("clear incomplete");
   a_full_overflow: assert property (host_wr_valid && fifo_count == 7'(DEPTH) && !clr |=> fifo_overflow)
      else $error("no overflow");
   a_empty_underflow: assert property (host_rd_req && fifo_count == 7'h00 && !cmd_valid |-> ##[1:2] fifo_underflow)
      else $error("no underflow");
   a_tx_crc: assert property (cmd_valid && op_en && op_tx_en && cmd_code == CMD_TX_CRC |=> tx_start && tx_crc)
      else $error("transmit not started");
   a_rx_mask: assert property (cmd_valid && op_en && op_rx_en && cmd_code == CMD_MASK_RX |=> rx_masked)
      else $error("receive not masked");
   a_irq_masked: assert property ($rose(irq) |-> !$past(irq_mask_wl) && irq_wl_flag)
      else $error("irq despite mask");
   a_irq_fall: assert property ($fell(irq) |-> $past(irq_read) || $past(clr) || $past(irq_mask_wl))
      else $error("irq fell unread");
   c_irq_rise: cover property ($rose(irq));
   c_overflow: cover property ($rose(fifo_overflow));
   c_tx_crc: cover property (tx_start && tx_crc);
endmodule : fwlc_fifo_properties
`default_nettype wire

// >>> fwlc_link_model.sv
`timescale 1ns/100ps
`default_nettype none
// Framing and demodulator stand-in on the link clock.
module fwlc_link_model (
   // Link clock.
   input wire logic link_clk,
   // Demodulated bytes toward the FIFO.
   output logic link_rx_valid,
   output logic [7:0] link_rx_data,
   // Transmitter requests and answers.
   output logic link_tx_req,
   input wire logic link_tx_valid,
   input wire logic [7:0] link_tx_data,
   input wire logic link_tx_underrun
);
   initial begin
      link_rx_valid = 1'b0;
      link_rx_data = 8'h00;
      link_tx_req = 1'b0;
   end
   // Data is inverted after the pulse to expose late sampling.
   task automatic send_rx(input logic [7:0] d);
      @(posedge link_clk);
      #1 link_rx_valid = 1'b1;
      link_rx_data = d;
      @(posedge link_clk);
      #1 link_rx_valid = 1'b0;
      link_rx_data = ~d;
      repeat (10) @(posedge link_clk);
   endtask : send_rx
   // One byte per request; unknown if no answer in time.
   task automatic pull_tx(output logic [7:0] d, output logic u);
      d = 8'hxx;
      u = 1'bx;
      @(posedge link_clk);
      #1 link_tx_req = 1'b1;
      @(posedge link_clk);
      #1 link_tx_req = 1'b0;
      for (int i = 0; i < 20 && link_tx_valid !== 1'b1; i++) begin
         @(posedge link_clk);
         #1;
      end
      if (link_tx_valid === 1'b1) begin
         d = link_tx_data;
         u = link_tx_underrun;
      end
      repeat (10) @(posedge link_clk);
   endtask : pull_tx
endmodule : fwlc_link_model
`default_nettype wire

// >>> fwlc_fifo_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
// Host side is driven here, the link side by the model.
module fwlc_fifo_bench;
   import fwlc_pkg::*;
   logic clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b0, spi_ss_n = 1'b1, cmd_valid = 1'b0, irq_read = 1'b0;
   logic host_wr_valid = 1'b0, host_rd_req = 1'b0, op_en = 1'b1, op_tx_en = 1'b1, op_rx_en = 1'b0;
   logic cfg_rx_wl_sel = 1'b1, cfg_tx_wl_sel = 1'b1, irq_mask_wl = 1'b0, link_rx_valid, link_tx_req, un;
   logic [7:0] host_wr_data = 8'h00, cmd_code = 8'h00, host_rd_data, link_rx_data, link_tx_data, b, e;
   logic [12:0] tx_frame_bytes = 13'h0004;
   logic [6:0] fifo_count;
   logic host_rd_valid, fifo_overflow, fifo_underflow, irq_wl_flag, irq, tx_start, tx_crc, rx_masked;
   logic link_tx_valid, link_tx_underrun;
   logic [7:0] q[$];
   int n_errors = 0, n_tests = 0, seed = 76;
   fwlc_fifo u_fwlc_fifo (.*);
   fwlc_link_model u_fwlc_link_model (.*);
   initial forever #5 clk = ~clk;
   initial begin
      #3;
      forever #7.5 link_clk = ~link_clk;
   end
   task automatic stop_test;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // Expected receive level for a select value.
   function automatic logic [6:0] rx_level(input logic s);
      return s ? RX_WL1 : RX_WL0;
   endfunction : rx_level
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic pulse(ref logic s);
      step(1);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask : pulse
   task automatic wr(input logic [7:0] d);
      host_wr_data = d;
      pulse(host_wr_valid);
   endtask : wr
   task automatic cmd(input logic [7:0] c);
      cmd_code = c;
      pulse(cmd_valid);
   endtask : cmd
   task automatic rd(output logic [7:0] d);
      pulse(host_rd_req);
      for (int i = 0; i < 3 && host_rd_valid !== 1'b1; i++) step(1);
      if (host_rd_valid !== 1'b1) begin
         n_errors++;
         stop_test;
      end
      d = host_rd_data;
   endtask : rd
   task automatic load(input int n);
      q.delete();
      repeat (n) begin
         b = 8'($random(seed));
         q.push_back(b);
         wr(b);
      end
   endtask : load
   initial begin
      #900000;
      n_errors++;
      stop_test;
   end
   initial begin
      #1 sys_rst = 1'b1;
      step(8);
      sys_rst = 1'b0;
      step(2);
      `CHK({fifo_count, fifo_overflow, fifo_underflow, irq}, 10'h000)
      load(5);
      `CHK(fifo_count, 7'h05)
      repeat (5) begin
         e = q.pop_front();
         rd(b);
         `CHK(b, e)
      end
      repeat (97) wr(8'h5a);
      `CHK({fifo_count, fifo_overflow}, {DEPTH_CNT, 1'b1})
      op_en = 1'b0;
      cmd(CMD_CLEAR_A);
      `CHK(fifo_count, DEPTH_CNT)
      op_en = 1'b1;
      cmd(CMD_CLEAR_B);
      `CHK({fifo_count, fifo_overflow}, 8'h00)
      rd(b);
      step(1);
      `CHK({b, fifo_underflow}, 9'h001)
      cmd(CMD_CLEAR_A);
      $display("host path test done");
      load(3);
      cmd(CMD_TX_NOCRC);
      `CHK({tx_start, tx_crc}, 2'b10)
      repeat (3) begin
         e = q.pop_front();
         u_fwlc_link_model.pull_tx(b, un);
         `CHK(b, e)
      end
      u_fwlc_link_model.pull_tx(b, un);
      `CHK({un, fifo_underflow}, 2'b11)
      op_tx_en = 1'b0;
      cmd(CMD_TX_CRC);
      `CHK(tx_start, 1'b0)
      op_tx_en = 1'b1;
      cmd(CMD_CLEAR_A);
      tx_frame_bytes = 13'h0064;
      load(17);
      cmd(CMD_TX_CRC);
      `CHK({tx_start, tx_crc, irq_wl_flag}, 3'b110)
      spi_ss_n = 1'b0;
      e = q.pop_front();
      step(2);
      rd(b);
      `CHK({b, irq_wl_flag}, {e, 1'b0})
      spi_ss_n = 1'b1;
      wr(b);
      u_fwlc_link_model.pull_tx(b, un);
      `CHK({irq_wl_flag, irq}, 2'b11)
      pulse(irq_read);
      step(2);
      `CHK({irq_wl_flag, irq}, 2'b00)
      cmd(CMD_CLEAR_A);
      irq_mask_wl = 1'b1;
      load(5);
      cmd(CMD_TX_NOCRC);
      repeat (2) begin
         `CHK(irq_wl_flag, 1'b0)
         u_fwlc_link_model.pull_tx(b, un);
      end
      `CHK({irq_wl_flag, irq}, 2'b10)
      pulse(irq_read);
      irq_mask_wl = 1'b0;
      cmd(CMD_CLEAR_A);
      $display("transmit test done");
      op_rx_en = 1'b1;
      for (int i = 1; i <= 64; i++) begin
         if (i == 64) `CHK(irq_wl_flag, 1'b0)
         u_fwlc_link_model.send_rx(8'($random(seed)));
      end
      `CHK({fifo_count, irq_wl_flag, irq}, {rx_level(cfg_rx_wl_sel), 2'b11})
      cmd(CMD_MASK_RX);
      u_fwlc_link_model.send_rx(8'h33);
      `CHK({rx_masked, fifo_count}, {1'b1, 7'h40})
      $display("receive test done");
      stop_test;
   end
endmodule : fwlc_fifo_bench
bind fwlc_fifo fwlc_fifo_properties #(.DEPTH(DEPTH), .FRAME_BITS(FRAME_BITS)) u_fwlc_fifo_properties (.*);
`default_nettype wire
